// >>> logic/arpt_timer.sv
// Auto-reload, capture and pulse-width timer with its data-space registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE_01 - Auto-reload overflow reloads counter, output goes high.
// RULE_02 - Auto-reload compare match drives output low.
// RULE_03 - Eight-bit counter steps on each prescaler tick.
// RULE_04 - Software keeps compare above reload value.
// RULE_05 - Software writes reload, then load and enable.
// RULE_06 - Pin clock only allowed in auto-reload.
// RULE_07 - Capture copies counter to reload, sets edge.
// RULE_08 - Capture-reset also clears counter and prescaler.
// RULE_09 - External load copies reload into counter.
// RULE_10 - Other modes: overflow high, match low.
// RULE_11 - Every counter load clears the prescaler.
// RULE_12 - Mode field bits 1-0 select mode.
// RULE_13 - Load bit 7 loads, reads as zero.
// RULE_14 - Enable bit 6 runs or freezes counting.
// RULE_15 - Output enable bit 5 gates pulse pin.
// RULE_16 - Interrupt when flag and its enable set.
// RULE_17 - Flags clear on zero write, keep on one.
// RULE_18 - Flags set on edge, match, overflow.
// RULE_19 - Software clears overflow writing 06h.
// RULE_20 - Software keeps clock settings while running.
// RULE_21 - Reset clears mode control register.
// RULE_22 - Edge select: enable bit, then polarity.
// RULE_23 - Clock source: internal, divide-three, pin.
// RULE_24 - Tap chooses division, count untouched.
module arpt_timer #(
  parameter int CNT_W = 8,
  parameter int PSC_W = 7
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Data-space register port.
  input wire logic [7:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  // Timer pins.
  input wire logic timerInPin,
  output logic pulseOutPin,
  // Interrupt request.
  output logic timerIrq
);
  generate
    if (CNT_W != 8) begin : g_bad_cnt
      $error("arpt_timer: CNT_W must be 8");
    end
  endgenerate

  arpt_psc_if #(.PSC_W(PSC_W)) pscBus ();

  logic [6:0] modeReg;
  logic [7:0] cfgReg;
  logic [7:0] reloadReg;
  logic [7:0] cmpReg;
  logic [7:0] cntReg;
  logic [7:0] cntNext;
  logic [2:0] flagReg;
  logic [1:0] div3Reg;
  logic pwmReg;
  logic pwmNext;
  logic pulseOutReg;
  logic [7:0] rdDataReg;

  logic runOn;

  // Write strobe for one register offset.
  function automatic logic wrAt(input logic [7:0] off);
    wrAt = regWrEn && (regAddr == off);
  endfunction

  arpt_pkg::arpt_mode_e modeSel;
  arpt_pkg::arpt_clk_e clkSel;
  logic div3Tick;
  logic activeEdge;
  logic pinRise;
  logic loadBitWr;
  logic loadRegWr;
  logic capEv;
  logic capReset;
  logic extLoad;
  logic cntWrap;
  logic stepped;
  logic reloadStep;
  logic ovfEv;
  logic cmpEv;
  logic anyLoad;
  logic [2:0] flagSet;
  logic [2:0] flagKeep;

  // RULE_12 - mode field decode.
  assign modeSel = arpt_pkg::arpt_mode_e'(modeReg[arpt_pkg::MODE_FIELD_LSB +: 2]);
  assign clkSel = arpt_pkg::arpt_clk_e'(cfgReg[arpt_pkg::CFG_CLK_LSB +: 2]);
  assign runOn = modeReg[arpt_pkg::MODE_RUN_BIT];

  // Divide-by-three enable for the slower internal source.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      div3Reg <= 2'h0;
    end else if (div3Reg == arpt_pkg::DIV3_LAST) begin
      div3Reg <= 2'h0;
    end else begin
      div3Reg <= div3Reg + 2'h1;
    end
  end
  assign div3Tick = (div3Reg == arpt_pkg::DIV3_LAST);

  arpt_edge_detect u_edge (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pinIn(timerInPin),
    .detectOn(cfgReg[arpt_pkg::CFG_EDGE_ON_BIT]),
    .fallSel(cfgReg[arpt_pkg::CFG_EDGE_FALL_BIT]),
    .activeEdge(activeEdge),
    .pinRise(pinRise)
  );

  // RULE_23 - clock source multiplexer.
  always_comb begin
    case (clkSel)
      arpt_pkg::ARPT_CLK_INT: pscBus.srcTick = 1'b1;
      arpt_pkg::ARPT_CLK_DIV3: pscBus.srcTick = div3Tick;
      arpt_pkg::ARPT_CLK_PIN: pscBus.srcTick = pinRise;
      default: pscBus.srcTick = 1'b0;
    endcase
  end

  // RULE_14 - enable gates the prescaler.
  assign pscBus.run = runOn;
  assign pscBus.tap = cfgReg[arpt_pkg::CFG_TAP_LSB +: 3];

  arpt_prescaler #(.PSC_W(PSC_W)) u_psc (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .pscBus(pscBus)
  );

  // RULE_13 - load bit acts on write only.
  assign loadBitWr = wrAt(arpt_pkg::ADDR_MODE) && regWrData[arpt_pkg::MODE_LOAD_BIT];
  assign loadRegWr = wrAt(arpt_pkg::ADDR_LOAD);
  assign capEv = activeEdge && (modeSel == arpt_pkg::ARPT_CAPTURE
                                || modeSel == arpt_pkg::ARPT_CAPTURE_RESET);
  assign capReset = activeEdge && (modeSel == arpt_pkg::ARPT_CAPTURE_RESET);
  // RULE_09 - edge load regardless of enable.
  assign extLoad = activeEdge && (modeSel == arpt_pkg::ARPT_EXT_LOAD);
  assign cntWrap = (cntReg == 8'hFF);
  assign stepped = pscBus.tick && !(loadRegWr || loadBitWr || capReset || extLoad);
  assign ovfEv = stepped && cntWrap;
  assign reloadStep = ovfEv && (modeSel == arpt_pkg::ARPT_AUTO_RELOAD);
  assign cmpEv = stepped && (cntNext == cmpReg);

  // RULE_11 - any counter load clears the prescaler.
  assign anyLoad = loadRegWr || loadBitWr || capReset || extLoad || reloadStep;
  assign pscBus.clear = anyLoad;

  // Core writes win over pin events; pin events win over counting.
  always_comb begin
    if (loadRegWr) begin
      cntNext = regWrData;
    end else if (loadBitWr) begin
      cntNext = reloadReg;
    end else if (capReset) begin
      // RULE_08 - capture also zeroes counter.
      cntNext = 8'h00;
    end else if (extLoad) begin
      // RULE_09 - copy reload into counter.
      cntNext = reloadReg;
    end else if (reloadStep) begin
      // RULE_01 - reload on overflow.
      cntNext = reloadReg;
    end else if (pscBus.tick) begin
      // RULE_03 - free-running increment.
      cntNext = cntReg + 8'h01;
    end else begin
      cntNext = cntReg;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cntReg <= arpt_pkg::DATA_RST;
    end else begin
      cntReg <= cntNext;
    end
  end

  // Pulse state: overflow sets, compare match clears and wins a tie.
  always_comb begin
    if (cmpEv) begin
      // RULE_02 - match drives output low.
      pwmNext = 1'b0;
    end else if (ovfEv) begin
      // RULE_10 - overflow drives output high.
      pwmNext = 1'b1;
    end else begin
      pwmNext = pwmReg;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwmReg <= 1'b0;
    end else begin
      pwmReg <= pwmNext;
    end
  end

  // RULE_15 - output enable gates the pin.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulseOutReg <= 1'b0;
    end else begin
      pulseOutReg <= pwmReg && modeReg[arpt_pkg::MODE_OE_BIT];
    end
  end
  assign pulseOutPin = pulseOutReg;

  // RULE_21 - mode control clears on reset.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      modeReg <= arpt_pkg::MODE_RST[6:0];
    end else if (wrAt(arpt_pkg::ADDR_MODE)) begin
      modeReg <= regWrData[6:0];
    end
  end

  // The reserved bit of the configuration register is not stored.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgReg <= arpt_pkg::CFG_RST;
    end else if (wrAt(arpt_pkg::ADDR_CFG)) begin
      cfgReg <= regWrData & 8'hEF;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmpReg <= arpt_pkg::DATA_RST;
    end else if (wrAt(arpt_pkg::ADDR_CMP)) begin
      cmpReg <= regWrData;
    end
  end

  // A capture in the same cycle as a core write keeps the captured value.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reloadReg <= arpt_pkg::DATA_RST;
    end else if (capEv) begin
      // RULE_07 - capture counter value.
      reloadReg <= cntReg;
    end else if (wrAt(arpt_pkg::ADDR_RELOAD)) begin
      reloadReg <= regWrData;
    end
  end

  // RULE_18 - hardware flag sources.
  assign flagSet = {activeEdge, cmpEv, ovfEv};
  // RULE_17 - zero clears, one keeps.
  assign flagKeep = wrAt(arpt_pkg::ADDR_FLAGS) ? regWrData[2:0] : 3'h7;

  // A flag set in the cycle of its clear stays set.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flagReg <= arpt_pkg::FLAGS_RST;
    end else begin
      flagReg <= (flagReg & flagKeep) | flagSet;
    end
  end

  // RULE_16 - flag and enable raise the request.
  assign timerIrq = |(flagReg & modeReg[arpt_pkg::MODE_OVF_IE_BIT +: 3]);

  // Read data is registered one cycle after the read strobe.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdDataReg <= 8'h00;
    end else if (regRdEn) begin
      case (regAddr)
        // RULE_13 - load bit reads zero.
        arpt_pkg::ADDR_MODE: rdDataReg <= {1'b0, modeReg};
        arpt_pkg::ADDR_FLAGS: rdDataReg <= {5'h00, flagReg};
        arpt_pkg::ADDR_CFG: rdDataReg <= cfgReg;
        arpt_pkg::ADDR_RELOAD: rdDataReg <= reloadReg;
        arpt_pkg::ADDR_CMP: rdDataReg <= cmpReg;
        arpt_pkg::ADDR_LOAD: rdDataReg <= cntReg;
        default: rdDataReg <= 8'h00;
      endcase
    end
  end
  assign regRdData = rdDataReg;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence sWrapReload;
    reloadStep && !cmpEv;
  endsequence

  sequence sPulseHigh;
    pwmReg ##1 (pulseOutPin == $past(modeReg[arpt_pkg::MODE_OE_BIT]));
  endsequence

  a_reload_on_wrap: assert property ( // RULE_01
    sWrapReload |=> (cntReg == $past(reloadReg)) ##0 sPulseHigh)
    else $error("overflow did not reload and raise the pulse");

  a_match_drops_pulse: assert property ( // RULE_02
    cmpEv |=> !pwmReg ##1 !pulseOutPin)
    else $error("compare match did not drop the pulse");

  a_count_step: assert property ( // RULE_03
    stepped && !cntWrap |=> cntReg == $past(cntReg) + 8'h01)
    else $error("counter did not step by one");

  a_capture_copy: assert property ( // RULE_07
    capEv |=> reloadReg == $past(cntReg) && flagReg[arpt_pkg::FLAG_EDGE_BIT])
    else $error("capture value or edge flag wrong");

  a_capreset_zero: assert property ( // RULE_08
    capReset && !loadRegWr && !loadBitWr |=> cntReg == 8'h00 && pscBus.count == '0)
    else $error("capture-reset did not clear counter and prescaler");

  a_ext_load_copy: assert property ( // RULE_09
    extLoad && !loadRegWr && !loadBitWr |=> cntReg == $past(reloadReg))
    else $error("external edge did not load counter");

  a_load_clears_psc: assert property ( // RULE_11
    anyLoad |=> pscBus.count == '0)
    else $error("counter load left prescaler uncleared");

  a_frozen_hold: assert property ( // RULE_14
    !runOn && !anyLoad |=> $stable(cntReg) && $stable(pscBus.count))
    else $error("counter moved while disabled");

  a_irq_from_flag: assert property ( // RULE_16
    flagReg[arpt_pkg::FLAG_CMP_BIT] && modeReg[arpt_pkg::MODE_CMP_IE_BIT] |-> timerIrq)
    else $error("enabled compare flag raised no request");

  a_flag_sticky: assert property ( // RULE_17
    flagReg[arpt_pkg::FLAG_OVF_BIT]
    && !(wrAt(arpt_pkg::ADDR_FLAGS) && !regWrData[arpt_pkg::FLAG_OVF_BIT])
    |=> flagReg[arpt_pkg::FLAG_OVF_BIT])
    else $error("overflow flag dropped without a clear");

  a_ovf_flag_set: assert property ( // RULE_18
    ovfEv |=> flagReg[arpt_pkg::FLAG_OVF_BIT])
    else $error("overflow did not set its flag");

  a_load_bit_zero: assert property ( // RULE_13
    regRdEn && regAddr == arpt_pkg::ADDR_MODE |=> !regRdData[arpt_pkg::MODE_LOAD_BIT])
    else $error("load bit read back as one");

endmodule
`default_nettype wire

// >>> logic/arpt_pkg.sv
// Shared constants and types of the auto-reload pulse and capture timer.
package arpt_pkg;

  // Data-space offsets of the timer registers.
  localparam logic [7:0] ADDR_MODE = 8'hD5;
  localparam logic [7:0] ADDR_FLAGS = 8'hD6;
  localparam logic [7:0] ADDR_CFG = 8'hD7;
  localparam logic [7:0] ADDR_RELOAD = 8'hD9;
  localparam logic [7:0] ADDR_CMP = 8'hDA;
  localparam logic [7:0] ADDR_LOAD = 8'hDB;

  // Mode control register bit positions.
  localparam int MODE_LOAD_BIT = 7;
  localparam int MODE_RUN_BIT = 6;
  localparam int MODE_OE_BIT = 5;
  localparam int MODE_EDGE_IE_BIT = 4;
  localparam int MODE_CMP_IE_BIT = 3;
  localparam int MODE_OVF_IE_BIT = 2;
  localparam int MODE_FIELD_LSB = 0;

  // Event flag register bit positions.
  localparam int FLAG_EDGE_BIT = 2;
  localparam int FLAG_CMP_BIT = 1;
  localparam int FLAG_OVF_BIT = 0;

  // Clock and edge configuration register field positions.
  localparam int CFG_TAP_LSB = 5;
  localparam int CFG_EDGE_FALL_BIT = 3;
  localparam int CFG_EDGE_ON_BIT = 2;
  localparam int CFG_CLK_LSB = 0;

  // Reset values.
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;

  // Timing: internal clock rate and the divide-by-three source.
  localparam int INTERNAL_CLOCK_FREQ_MHZ = 200;
  localparam logic [1:0] DIV3_LAST = 2'h2;

  typedef enum logic [1:0] {
    ARPT_AUTO_RELOAD = 2'h0,
    ARPT_CAPTURE = 2'h1,
    ARPT_CAPTURE_RESET = 2'h2,
    ARPT_EXT_LOAD = 2'h3
  } arpt_mode_e;

  typedef enum logic [1:0] {
    ARPT_CLK_INT = 2'h0,
    ARPT_CLK_DIV3 = 2'h1,
    ARPT_CLK_PIN = 2'h2,
    ARPT_CLK_NONE = 2'h3
  } arpt_clk_e;

endpackage

// >>> logic/arpt_psc_if.sv
// Link between the timer core and its prescaler.
`timescale 1ns/1ps
`default_nettype none
interface arpt_psc_if #(parameter int PSC_W = 7);
  logic srcTick;
  logic clear;
  logic run;
  logic [2:0] tap;
  logic tick;
  logic [PSC_W-1:0] count;
  modport ctrl (output srcTick, output clear, output run, output tap,
                input tick, input count);
  modport psc (input srcTick, input clear, input run, input tap,
               output tick, output count);
endinterface
`default_nettype wire

// >>> logic/arpt_edge_detect.sv
// Input pin edge detector for capture, load and pin-clock use.
`timescale 1ns/1ps
`default_nettype none
module arpt_edge_detect (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Pin and edge selection.
  input wire logic pinIn,
  input wire logic detectOn,
  input wire logic fallSel,
  // Events.
  output logic activeEdge,
  output logic pinRise
);
  logic prevReg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prevReg <= 1'b0;
    end else begin
      prevReg <= pinIn;
    end
  end

  assign pinRise = pinIn & ~prevReg;
  // RULE_22 - edge select decode.
  assign activeEdge = detectOn & (fallSel ? (prevReg & ~pinIn) : pinRise);
endmodule
`default_nettype wire

// >>> logic/arpt_prescaler.sv
// Seven-bit prescaler with a selectable power-of-two tap.
`timescale 1ns/1ps
`default_nettype none
module arpt_prescaler #(parameter int PSC_W = 7) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Control from the timer core.
  arpt_psc_if.psc pscBus
);
  generate
    if (PSC_W < 1 || PSC_W > 7) begin : g_bad_width
      $error("arpt_prescaler: PSC_W must be 1 to 7");
    end
  endgenerate

  logic [PSC_W-1:0] countReg;
  logic [PSC_W-1:0] tapMask;

  // The tap output rises when its low bits pass all ones below its top bit.
  assign tapMask = PSC_W'((8'h01 << pscBus.tap) - 8'h01);
  // RULE_24 - tap only selects.
  assign pscBus.tick = pscBus.run & pscBus.srcTick
                       & ((countReg & tapMask) == (tapMask >> 1));
  assign pscBus.count = countReg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      countReg <= '0;
    end else if (pscBus.clear) begin
      countReg <= '0;
    end else if (pscBus.run && pscBus.srcTick) begin
      countReg <= countReg + 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> tb/arpt_pin_model.sv
// Model of the external timer input pin driven by the outside world.
`timescale 1ns/1ps
`default_nettype none
module arpt_pin_model (
  // Clock.
  input wire logic sys_clk,
  // Pin.
  output logic pin
);
  initial pin = 1'h0;

  // Each rise is held two cycles high and three low so every one is seen once.
  task automatic rises(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge sys_clk);
      pin = 1'h1;
      repeat (2) @(negedge sys_clk);
      pin = 1'h0;
      repeat (2) @(negedge sys_clk);
    end
  endtask

  // Two rises a set number of cycles apart, then the pin rests low.
  task automatic pair(input int gap);
    @(negedge sys_clk);
    pin = 1'h1;
    @(negedge sys_clk);
    pin = 1'h0;
    repeat (gap - 1) @(negedge sys_clk);
    pin = 1'h1;
    @(negedge sys_clk);
    pin = 1'h0;
    repeat (3) @(negedge sys_clk);
  endtask

  // Moves the pin to a level and lets the resulting event settle.
  task automatic level(input logic v);
    @(negedge sys_clk);
    pin = v;
    repeat (3) @(negedge sys_clk);
  endtask
endmodule
`default_nettype wire

// >>> tb/arpt_timer_bench.sv
// Self-checking bench for the auto-reload pulse and capture timer.
`timescale 1ns/1ps
`default_nettype none
module arpt_timer_bench;
  logic sysClk;
  logic sysRst;
  logic [7:0] regAddr;
  logic regWrEn;
  logic [7:0] regWrData;
  logic regRdEn;
  logic [7:0] regRdData;
  wire logic pinLvl;
  logic pulseOut;
  logic irq;
  int badCount;
  int cmpCount;
  int seed;

  initial sysClk = 1'h0;
  always #2.5 sysClk = ~sysClk;

  arpt_timer i_dut (.sys_clk(sysClk), .sys_rst(sysRst), .regAddr(regAddr), .regWrEn(regWrEn),
    .regWrData(regWrData), .regRdEn(regRdEn), .regRdData(regRdData), .timerInPin(pinLvl),
    .pulseOutPin(pulseOut), .timerIrq(irq));
  arpt_pin_model u_pin (.sys_clk(sysClk), .pin(pinLvl));

  task automatic wrapUp();
    $display("TB: mismatches=%0d compares=%0d", badCount, cmpCount);
    if (badCount == 0 && cmpCount > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One write strobe; a full cycle passes before the next one can rise.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sysClk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'h1;
    @(negedge sysClk);
    regWrEn = 1'h0;
    regWrData = 8'($random(seed));
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge sysClk);
    regAddr = a;
    regRdEn = 1'h1;
    @(negedge sysClk);
    regRdEn = 1'h0;
    regAddr = 8'($random(seed));
    chk(regRdData, exp);
  endtask

  function automatic logic [7:0] cfgWord(input logic [2:0] tap, input logic [1:0] edgeSel,
      input arpt_pkg::arpt_clk_e src);
    return {tap, 1'h0, edgeSel, src};
  endfunction

  function automatic logic [7:0] afterTicks(input logic [7:0] r, input int n);
    return r + n[7:0];
  endfunction

  function automatic logic [7:0] capCount(input int m, input logic [7:0] v, input logic [7:0] w);
    return (m == 1) ? v : ((m == 2) ? 8'h00 : w);
  endfunction

  initial begin
    #300000;
    badCount++;
    wrapUp();
  end

  initial begin
    logic [31:0] tmp;
    logic [7:0] r;
    logic [7:0] e;
    int n;
    seed = 32'h9CD0E3EC;
    sysRst = 1'h1;
    regAddr = 8'h00;
    regWrEn = 1'h0;
    regWrData = 8'h00;
    regRdEn = 1'h0;
    repeat (5) @(negedge sysClk);
    sysRst = 1'h0;
    rdChk(arpt_pkg::ADDR_MODE, 8'h00);
    rdChk(arpt_pkg::ADDR_FLAGS, 8'h00);
    rdChk(8'hD8, 8'h00);
    for (int tap = 0; tap < 8; tap++) begin
      tmp = $random(seed);
      r = {1'h0, tmp[6:0]};
      n = 1 + tmp[9:8];
      wr(arpt_pkg::ADDR_MODE, 8'h00);
      wr(arpt_pkg::ADDR_CFG, cfgWord(tap[2:0], 2'h0, arpt_pkg::ARPT_CLK_PIN));
      wr(arpt_pkg::ADDR_RELOAD, r);
      wr(arpt_pkg::ADDR_MODE, 8'hC0);
      rdChk(arpt_pkg::ADDR_MODE, 8'h40);
      u_pin.rises(n << tap);
      e = afterTicks(r, n);
      rdChk(arpt_pkg::ADDR_LOAD, e);
    end
    wr(arpt_pkg::ADDR_MODE, 8'h00);
    u_pin.rises(3);
    rdChk(arpt_pkg::ADDR_LOAD, e);
    tmp = $random(seed);
    r = {4'hE, tmp[3:0]};
    wr(arpt_pkg::ADDR_CFG, cfgWord(3'h0, 2'h0, arpt_pkg::ARPT_CLK_PIN));
    wr(arpt_pkg::ADDR_RELOAD, r);
    wr(arpt_pkg::ADDR_CMP, r + 8'h02);
    wr(arpt_pkg::ADDR_MODE, 8'hE4);
    u_pin.rises(255 - r);
    rdChk(arpt_pkg::ADDR_FLAGS, 8'h02);
    u_pin.rises(1);
    rdChk(arpt_pkg::ADDR_LOAD, r);
    rdChk(arpt_pkg::ADDR_FLAGS, 8'h03);
    chk({7'h00, pulseOut}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    wr(arpt_pkg::ADDR_MODE, 8'h44);
    repeat (2) @(negedge sysClk);
    chk({7'h00, pulseOut}, 8'h00);
    wr(arpt_pkg::ADDR_MODE, 8'h64);
    repeat (2) @(negedge sysClk);
    chk({7'h00, pulseOut}, 8'h01);
    wr(arpt_pkg::ADDR_FLAGS, 8'h06);
    rdChk(arpt_pkg::ADDR_FLAGS, 8'h02);
    chk({7'h00, irq}, 8'h00);
    u_pin.rises(2);
    chk({7'h00, pulseOut}, 8'h00);
    wr(arpt_pkg::ADDR_FLAGS, 8'hFD);
    rdChk(arpt_pkg::ADDR_FLAGS, 8'h00);
    // capture, capture-reset and external load with a frozen counter.
    wr(arpt_pkg::ADDR_MODE, 8'h00);
    wr(arpt_pkg::ADDR_CFG, cfgWord(3'h0, 2'h1, arpt_pkg::ARPT_CLK_INT));
    for (int m = 1; m < 4; m++) begin
      tmp = $random(seed);
      wr(arpt_pkg::ADDR_RELOAD, tmp[15:8]);
      wr(arpt_pkg::ADDR_LOAD, tmp[7:0]);
      wr(arpt_pkg::ADDR_MODE, {6'h04, m[1:0]});
      u_pin.level(1'h1);
      rdChk(arpt_pkg::ADDR_FLAGS, 8'h04);
      chk({7'h00, irq}, 8'h01);
      rdChk(arpt_pkg::ADDR_RELOAD, (m == 3) ? tmp[15:8] : tmp[7:0]);
      rdChk(arpt_pkg::ADDR_LOAD, capCount(m, tmp[7:0], tmp[15:8]));
      u_pin.level(1'h0);
      wr(arpt_pkg::ADDR_FLAGS, 8'h00);
    end
    wr(arpt_pkg::ADDR_MODE, 8'h01);
    wr(arpt_pkg::ADDR_CFG, cfgWord(3'h0, 2'h3, arpt_pkg::ARPT_CLK_INT));
    u_pin.level(1'h1);
    rdChk(arpt_pkg::ADDR_FLAGS, 8'h00);
    u_pin.level(1'h0);
    rdChk(arpt_pkg::ADDR_FLAGS, 8'h04);
    wr(arpt_pkg::ADDR_FLAGS, 8'h00);
    wr(arpt_pkg::ADDR_CFG, cfgWord(3'h0, 2'h2, arpt_pkg::ARPT_CLK_INT));
    u_pin.level(1'h1);
    u_pin.level(1'h0);
    rdChk(arpt_pkg::ADDR_FLAGS, 8'h00);
    // overflow raises, match drops, capture mode.
    wr(arpt_pkg::ADDR_CMP, 8'h80);
    wr(arpt_pkg::ADDR_LOAD, 8'hFD);
    wr(arpt_pkg::ADDR_MODE, 8'h61);
    repeat (8) @(negedge sysClk);
    chk({7'h00, pulseOut}, 8'h01);
    repeat (200) @(negedge sysClk);
    chk({7'h00, pulseOut}, 8'h00);
    wr(arpt_pkg::ADDR_MODE, 8'h01);
    rdChk(arpt_pkg::ADDR_FLAGS, 8'h03);
    wr(arpt_pkg::ADDR_FLAGS, 8'h00);
    // divide-by-three source, timed by capture with reset.
    tmp = $random(seed);
    n = 1 + tmp[3:0];
    wr(arpt_pkg::ADDR_CFG, cfgWord(3'h0, 2'h1, arpt_pkg::ARPT_CLK_DIV3));
    wr(arpt_pkg::ADDR_MODE, 8'h42);
    u_pin.pair(3 * n + 1);
    wr(arpt_pkg::ADDR_MODE, 8'h02);
    rdChk(arpt_pkg::ADDR_RELOAD, n[7:0]);
    wr(arpt_pkg::ADDR_FLAGS, 8'h00);
    wr(arpt_pkg::ADDR_MODE, 8'h7F);
    @(negedge sysClk);
    sysRst = 1'h1;
    @(negedge sysClk);
    sysRst = 1'h0;
    rdChk(arpt_pkg::ADDR_MODE, 8'h00);
    wrapUp();
  end
endmodule
`default_nettype wire
